// ### logic/cpl_regs.svh
`ifndef CPL_REGS_SVH
`define CPL_REGS_SVH

// ======================================================================
// Register byte offsets on the APB
`define CPL_OFS_STATUS      12'h000
`define CPL_OFS_CORE_CTRL   12'h004
`define CPL_OFS_INT_CTRL1   12'h008

// ======================================================================
// Field positions
`define CPL_LOW_MSB         7
`define CPL_LOW_LSB         5
`define CPL_TOP_BIT         3
`define CPL_NEST_BIT        15

// ======================================================================
// Reset values
`define CPL_RST_LOW         3'h0
`define CPL_RST_TOP         1'h0
`define CPL_RST_NEST        1'h0

// ======================================================================
// Level figures
`define CPL_LOW_MAX         3'h7
`define CPL_TOP_OFFSET      4'h8

`endif

// ### logic/cpl_pkg.sv
package cpl_pkg;

  // ====================================================================
  // Types
  typedef logic [3:0]  cpl_level_t;
  typedef logic [2:0]  cpl_low_t;
  typedef logic [31:0] cpl_word_t;

endpackage : cpl_pkg

// ### logic/cpl_priority_level.sv
// Overview of operation
// - Level is four bits: status bits 7:5 low, core control bit 3 top.
// - Top bit clear: low bits give level 0 to 7 directly.
// - Top bit set: level equals low bits plus eight, 8 to 15.
// - Low bits 111 give level 7 or 15 and mask all user interrupts.
// - Top bit set masks every user interrupt whatever the low bits.
// - Nesting disable set makes low bits read-only to software writes.
// - Top bit reads one when level exceeds 7, zero otherwise.
//
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "cpl_regs.svh"

module cpl_priority_level #(
  parameter int ADDR_W = 12
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [ADDR_W-1:0]     paddr,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  hw_level_load,
  input  wire logic [3:0]            hw_level,
  input  wire logic                  user_req_valid,
  input  wire logic [2:0]            user_req_prio,
  output logic      [3:0]            effective_level,
  output logic                       user_masked,
  output logic                       user_irq
);

  // ====================================================================
  // Elaboration check
  // The map ends at word 0x008, so a narrower bus cannot reach every word
  if (ADDR_W < 4) begin : g_bad_addr
    $error("ADDR_W too small for the register map");
  end

  // ====================================================================
  // Helpers
  // Effective level from the two split fields
  function automatic cpl_pkg::cpl_level_t cpl_level_of(
    input logic               top,
    input cpl_pkg::cpl_low_t  low
  );
    cpl_level_of = top ? (`CPL_TOP_OFFSET + {1'b0, low})
                       : {1'b0, low};
  endfunction : cpl_level_of

  // Whether user interrupts are blocked at this setting
  function automatic logic cpl_masked_of(
    input logic               top,
    input cpl_pkg::cpl_low_t  low
  );
    cpl_masked_of = top | (low == `CPL_LOW_MAX);
  endfunction : cpl_masked_of

  // ====================================================================
  // State
  cpl_pkg::cpl_low_t   low_r;
  cpl_pkg::cpl_low_t   low_nxt;
  logic                top_r;
  logic                top_nxt;
  logic                nest_r;
  logic                nest_nxt;
  logic                pready_r;
  logic                pslverr_r;
  cpl_pkg::cpl_word_t  prdata_r;
  cpl_pkg::cpl_level_t level_r;
  logic                masked_r;
  logic                irq_r;

  // Level and mask of the fields as they stand now, read by the checks
  // so that they never lean on the registered outputs they judge
  wire cpl_pkg::cpl_level_t level_of_now  = cpl_level_of(top_r, low_r);
  wire                      masked_of_now = cpl_masked_of(top_r, low_r);

  // ====================================================================
  // Bus decode
  // Access completes on the second access-phase cycle, one wait state
  // Strobes gate writes per byte lane; reads ignore them
  wire        acc_go   = psel & penable & ~pready_r;
  wire        acc_done = psel & penable & pready_r;
  wire        hit_st   = (paddr == ADDR_W'(`CPL_OFS_STATUS));
  wire        hit_cc   = (paddr == ADDR_W'(`CPL_OFS_CORE_CTRL));
  wire        hit_ic   = (paddr == ADDR_W'(`CPL_OFS_INT_CTRL1));
  wire        hit_any  = hit_st | hit_cc | hit_ic;
  wire        wr_st    = acc_done & pwrite & hit_st & pstrb[0];
  wire        wr_cc    = acc_done & pwrite & hit_cc & pstrb[0];
  wire        wr_ic    = acc_done & pwrite & hit_ic & pstrb[1];

  // Read words; unused bits read zero
  wire cpl_pkg::cpl_word_t rd_st =
    {24'h000000, low_r, 5'h00};
  wire cpl_pkg::cpl_word_t rd_cc =
    {28'h0000000, top_r, 3'h0};
  wire cpl_pkg::cpl_word_t rd_ic =
    {16'h0000, nest_r, 15'h0000};
  wire cpl_pkg::cpl_word_t rd_mux =
    hit_st ? rd_st : hit_cc ? rd_cc : hit_ic ? rd_ic : 32'h00000000;

  // ====================================================================
  // Next-state of the level fields
  // Core load wins over software writes to the low and top bits in the same
  // cycle, so a hardware raise of the top bit is never lost to a software clear.
  always_comb begin
    low_nxt  = low_r;
    top_nxt  = top_r;
    nest_nxt = nest_r;
    if (hw_level_load) begin
      low_nxt = hw_level[2:0];
      top_nxt = hw_level[3];
    end else begin
      if (wr_st && !nest_r) begin
        low_nxt = pwdata[`CPL_LOW_MSB:`CPL_LOW_LSB];
      end
      if (wr_cc && !pwdata[`CPL_TOP_BIT]) begin
        top_nxt = 1'b0;
      end
    end
    if (wr_ic) begin
      nest_nxt = pwdata[`CPL_NEST_BIT];
    end
  end

  // ====================================================================
  // Register file
  // Only constants in the reset branch; nesting disable starts clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_r  <= `CPL_RST_LOW;
      top_r  <= `CPL_RST_TOP;
      nest_r <= `CPL_RST_NEST;
    end else begin
      low_r  <= low_nxt;
      top_r  <= top_nxt;
      nest_r <= nest_nxt;
    end
  end

  // ====================================================================
  // APB answer
  // One wait state keeps read data a plain flop, so no path runs from
  // paddr to prdata within a cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h00000000;
    end else begin
      pready_r  <= acc_go;
      pslverr_r <= acc_go & ~hit_any;
      prdata_r  <= (acc_go & ~pwrite) ? rd_mux : 32'h00000000;
    end
  end

  // ====================================================================
  // Level, mask and request outputs
  // Registered for clean timing; they lag the fields by one cycle.
  // A request at exactly the level is held back; only higher passes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_r  <= 4'h0;
      masked_r <= 1'b0;
      irq_r    <= 1'b0;
    end else begin
      level_r  <= cpl_level_of(top_r, low_r);
      masked_r <= cpl_masked_of(top_r, low_r);
      irq_r    <= user_req_valid
                  & ~cpl_masked_of(top_r, low_r)
                  & ({1'b0, user_req_prio} > cpl_level_of(top_r, low_r));
    end
  end

  assign prdata          = prdata_r;
  assign pready          = pready_r;
  assign pslverr         = pslverr_r;
  assign effective_level = level_r;
  assign user_masked     = masked_r;
  assign user_irq        = irq_r;

  // ====================================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Outputs are registered, so most checks look one edge after the
  // fields or the bus cycle that caused them

  chk_level_low_form: assert property (
    !top_r |=> level_r == {1'b0, $past(low_r)})
    else $error("level wrong with top bit clear");

  chk_level_high_form: assert property (
    top_r |=> level_r == 4'h8 + {1'b0, $past(low_r)})
    else $error("level wrong with top bit set");

  chk_low_max_mask: assert property (
    low_r == 3'h7 |=> user_masked && !user_irq)
    else $error("low bits 111 did not mask");

  chk_top_blocks_all: assert property (
    top_r |=> user_masked && !user_irq)
    else $error("top bit set but request passed");

  chk_nest_locks_low: assert property (
    nest_r && !hw_level_load |=> $stable(low_r))
    else $error("low bits changed while nesting disabled");

  chk_top_read_value: assert property (
    acc_go && !pwrite && hit_cc
    |=> prdata[3] == (level_r > 4'h7) || $past(hw_level_load, 2))
    else $error("top bit read disagrees with level");

  chk_top_no_sw_set: assert property (
    !top_r && !hw_level_load |=> !top_r)
    else $error("top bit set without hardware load");

  chk_irq_strict: assert property (
    user_irq |-> $past(user_req_valid)
      && {1'b0, $past(user_req_prio)} > $past(level_of_now))
    else $error("request passed at or below the level");

  chk_apb_one_wait: assert property (
    psel && penable && !pready |=> pready ##1 !pready)
    else $error("APB answer timing broken");

  // ====================================================================
  // Checks on the level fields
  // Fields follow a core load whatever software does in that cycle
  chk_hw_load_wins: assert property (
    hw_level_load |=> {top_r, low_r} == $past(hw_level))
    else $error("core load did not reach the level fields");

  // An open write with its strobe lands in the low bits
  chk_low_write_lands: assert property (
    wr_st && !nest_r && !hw_level_load
    |=> low_r == $past(pwdata[`CPL_LOW_MSB:`CPL_LOW_LSB]))
    else $error("status write did not reach the low bits");

  // A write with its byte strobe low leaves the low bits alone
  chk_strobe_gates_low: assert property (
    acc_done && pwrite && hit_st && !pstrb[0] && !hw_level_load
    |=> $stable(low_r))
    else $error("status write landed with its strobe low");

  // Software clears the top bit with a zero in its place
  chk_top_sw_clear: assert property (
    wr_cc && !pwdata[`CPL_TOP_BIT] && !hw_level_load |=> !top_r)
    else $error("top bit survived a software clear");

  // A one written to the top bit changes nothing
  chk_top_one_ignored: assert property (
    wr_cc && pwdata[`CPL_TOP_BIT] && !hw_level_load |=> $stable(top_r))
    else $error("writing one moved the top bit");

  // The output level is above seven exactly when the top bit was set
  chk_level_top_bit: assert property (
    1'b1 |=> (level_r > 4'h7) == $past(top_r))
    else $error("level range disagrees with the top bit");

  // Below level seven with the top bit clear nothing is masked
  chk_mask_clear_free: assert property (
    !top_r && low_r != `CPL_LOW_MAX |=> !user_masked)
    else $error("requests masked below level seven");

  // ====================================================================
  // Checks on the request path
  // No request in means no request out on the next cycle
  chk_irq_needs_valid: assert property (
    !user_req_valid |=> !user_irq)
    else $error("request presented without a valid source");

  // A request above an unmasked level must reach the processor
  chk_irq_above_level: assert property (
    user_req_valid && !masked_of_now
    && ({1'b0, user_req_prio} > level_of_now) |=> user_irq)
    else $error("request above the level was held back");

  // ====================================================================
  // Checks on the register bus
  // Status reads show the low bits in their place and nothing else
  chk_status_read_form: assert property (
    acc_go && !pwrite && hit_st
    |=> prdata == {24'h000000, $past(low_r), 5'h00})
    else $error("status read word malformed");

  // Unmapped words answer with an error; mapped ones never do
  chk_err_unmapped: assert property (
    acc_go && !hit_any |=> pslverr && pready)
    else $error("unmapped access answered without error");

  chk_err_mapped: assert property (
    acc_go && hit_any |=> !pslverr)
    else $error("mapped access answered with error");

  // Read data is zero outside the answer cycle, so no stale word leaks
  chk_rdata_idle: assert property (
    !pready |-> prdata == 32'h00000000)
    else $error("read data present outside the answer");

endmodule : cpl_priority_level

// ### tb/cpl_priority_level_tb.sv
`timescale 1ns/1ps
`include "cpl_regs.svh"

// Case equality so that an unknown never passes for a match
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fails++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end

module cpl_priority_level_tb;
  // ==================================================================
  // Signals
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0]  pstrb, hw_level, effective_level;
  logic [2:0]  user_req_prio;
  logic        hw_level_load, user_req_valid, user_masked, user_irq, err;
  int          fails, checks_done;

  cpl_priority_level i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hw_level_load(hw_level_load), .hw_level(hw_level),
    .user_req_valid(user_req_valid), .user_req_prio(user_req_prio),
    .effective_level(effective_level), .user_masked(user_masked),
    .user_irq(user_irq));

  // ==================================================================
  // Bus tasks; a spare edge after release keeps drivers single per step
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // No limit of its own: only the watchdog ends a hung wait
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rdat = prdata;
    err  = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, 4'h0);
    `CHK(rdat, e)
  endtask : rchk

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick

  // ==================================================================
  // Scenarios
  task automatic t_low;
    for (int v = 0; v < 8; v++) begin
      apb(1'b1, `CPL_OFS_STATUS, {24'h0, v[2:0], 5'h0}, 4'h1);
      tick(2);
      `CHK(effective_level, 4'(v))
      `CHK(user_masked, 1'(v == 7))
      rchk(`CPL_OFS_STATUS, {24'h0, v[2:0], 5'h0});
    end
  endtask : t_low

  task automatic t_top;
    apb(1'b1, `CPL_OFS_CORE_CTRL, 32'h8, 4'h1);
    tick(2);
    `CHK(effective_level, 4'h7)
    hw_level <= 4'hb; hw_level_load <= 1'b1;
    @(posedge pclk);
    hw_level_load <= 1'b0;
    tick(2);
    `CHK(effective_level, 4'hb)
    `CHK(user_masked, 1'b1)
    rchk(`CPL_OFS_CORE_CTRL, 32'h8);
    apb(1'b1, `CPL_OFS_CORE_CTRL, 32'h0, 4'h1);
    tick(2);
    `CHK(effective_level, 4'h3)
    rchk(`CPL_OFS_CORE_CTRL, 32'h0);
  endtask : t_top

  task automatic t_nest;
    apb(1'b1, `CPL_OFS_INT_CTRL1, 32'h8000, 4'h2);
    apb(1'b1, `CPL_OFS_STATUS, 32'he0, 4'h1);
    tick(2);
    `CHK(effective_level, 4'h3)
    rchk(`CPL_OFS_STATUS, 32'h60);
    apb(1'b1, `CPL_OFS_INT_CTRL1, 32'h0, 4'h2);
    // Byte strobe low: the write must be dropped
    apb(1'b1, `CPL_OFS_STATUS, 32'he0, 4'h0);
    rchk(`CPL_OFS_STATUS, 32'h60);
  endtask : t_nest

  // Priority equal to the level must not pass, one above must
  task automatic t_irq;
    user_req_valid <= 1'b1; user_req_prio <= 3'h3;
    tick(3);
    `CHK(user_irq, 1'b0)
    user_req_prio <= 3'h4;
    tick(3);
    `CHK(user_irq, 1'b1)
    user_req_valid <= 1'b0;
    apb(1'b0, 12'h00c, 32'h0, 4'h0);
    `CHK(err, 1'b1)
    `CHK(rdat, 32'h0)
  endtask : t_irq

  // ==================================================================
  // Verdict, reached from the main sequence or the watchdog
  task automatic results;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : results

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  initial begin
    repeat (4000) @(posedge pclk);
    fails++;
    results();
  end

  initial begin
    {presetn, psel, penable, pwrite, hw_level_load, user_req_valid} = '0;
    {paddr, pwdata, pstrb, hw_level, user_req_prio} = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK(effective_level, 4'h0)
    rchk(`CPL_OFS_CORE_CTRL, 32'h0);
    t_low();
    t_top();
    t_nest();
    t_irq();
    results();
  end
endmodule : cpl_priority_level_tb
